/* hdl/ir_uart_sets_timer_framelen.sv */
// register sets three to five: version, mirrors, timer, frame lengths, flow divisor
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module ir_uart_sets_timer_framelen #(
    parameter int TICK_CYCLES = irsets_pkg::TICK_CYCLES,
    parameter logic [irsets_pkg::DATA_W-1:0] VERSION_ID = irsets_pkg::VERSION_DEFAULT
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [irsets_pkg::ADDR_W-1:0] ADDR,
    input wire logic [irsets_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [irsets_pkg::DATA_W-1:0] RDATA,
    input wire logic [irsets_pkg::DATA_W-1:0] MIRROR_CTRL,
    input wire logic [irsets_pkg::DATA_W-1:0] MIRROR_FIFO_CTRL,
    input wire logic [irsets_pkg::DATA_W-1:0] FS_QUEUE_BOTTOM,
    input wire logic [irsets_pkg::FLEN_W-1:0] RX_LEN_QUEUE,
    input wire logic TIMER_FLAG_CLR,
    input wire logic TX_BYTE_SENT,
    input wire logic TX_STREAM_END,
    input wire logic RX_START_FLAG,
    input wire logic RX_BYTE_IN,
    input wire logic FAST_MODE,
    output logic [irsets_pkg::DATA_W-1:0] BANK_SEL,
    output logic TIMER_IRQ_FLAG,
    output logic [irsets_pkg::MODE_W-1:0] IR_MODE,
    output logic AUTO_PACKET,
    output logic TX_FRAME_SPLIT,
    output logic RX_FIFO_WE,
    output logic MAX_LEN_EXCEEDED,
    output logic ADV_DIV_LOAD,
    output logic [irsets_pkg::DIV_W-1:0] ADV_DIV
);
    import irsets_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] sel;
        logic [TMR_W-1:0] tmr_prog;
        logic [TMR_W-1:0] tmr_cnt;
        logic [MODE_W-1:0] mode;
        logic tmr_test;
        logic tmr_en;
        logic tmr_flag;
        logic [FLEN_W-1:0] tx_len;
        logic [FLEN_W-1:0] tx_rem;
        logic tx_split;
        logic [FLEN_W-1:0] rx_lim;
        logic [FLEN_W-1:0] rx_cnt;
        logic rx_exc;
        logic rx_we;
        logic [DIV_W-1:0] fdiv;
        logic [DATA_W-1:0] fcmd;
        logic [DATA_W-1:0] cfg1;
        logic fast_q;
        logic [DIV_W-1:0] adv_div;
        logic adv_load;
        logic [DATA_W-1:0] rdata;
    } regs_s;

    regs_s st_r;
    regs_s st_nxt;
    logic ms_tick;

    // true when the selector addresses the given set
    function automatic logic in_set(input logic [DATA_W-1:0] sel,
                                    input logic [DATA_W-1:0] code);
        in_set = (sel == code);
    endfunction

    // low and high byte view of a 13-bit length
    function automatic logic [DATA_W-1:0] len_byte(input logic [FLEN_W-1:0] v,
                                                   input logic hi);
        len_byte = hi ? {{(DATA_W-HI_W){1'b0}}, v[FLEN_W-1:DATA_W]} : v[DATA_W-1:0];
    endfunction

    ms_prescaler #(
        .CYCLES(TICK_CYCLES)
    ) u_pre (
        .clk(CLK),
        .srst(SRST),
        .tick(ms_tick)
    );

    logic s3;
    logic s4;
    logic s5;
    logic [TMR_W-1:0] tmr_view;
    logic automatic_packet_mode;

    assign s3 = in_set(st_r.sel, SEL_SET3);
    assign s4 = in_set(st_r.sel, SEL_SET4);
    assign s5 = in_set(st_r.sel, SEL_SET5);
    assign automatic_packet_mode = st_r.cfg1[CFG1_AUTO_PACKET_BIT];
    assign tmr_view = st_r.tmr_test ? st_r.tmr_prog : st_r.tmr_cnt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tx_split = 1'b0;
        st_nxt.rx_we = 1'b0;
        st_nxt.adv_load = 1'b0;
        st_nxt.rdata = BYTE_ZERO;
        st_nxt.fast_q = FAST_MODE;

        // register reads, data appears the next cycle
        if (RD) begin
            if (ADDR == OFS_SEL) begin
                if (s3) begin
                    st_nxt.rdata = SEL_SET3;
                end else if (s4) begin
                    st_nxt.rdata = SEL_SET4;
                end else if (s5) begin
                    st_nxt.rdata = SEL_SET5;
                end
            end else if (s3) begin
                case (ADDR)
                    OFS_0: st_nxt.rdata = VERSION_ID;
                    OFS_1: st_nxt.rdata = MIRROR_CTRL;
                    OFS_2: st_nxt.rdata = MIRROR_FIFO_CTRL;
                    default: st_nxt.rdata = BYTE_ZERO;
                endcase
            end else if (s4) begin
                case (ADDR)
                    OFS_0: st_nxt.rdata = tmr_view[DATA_W-1:0];
                    OFS_1: st_nxt.rdata = {{(DATA_W-THI_W){1'b0}},
                                           tmr_view[TMR_W-1:DATA_W]};
                    OFS_2: st_nxt.rdata = {{(DATA_W-MODE_W-2){1'b0}}, st_r.mode,
                                           st_r.tmr_test, st_r.tmr_en};
                    OFS_4: st_nxt.rdata = len_byte(st_r.tx_rem, 1'b0);
                    OFS_5: st_nxt.rdata = len_byte(st_r.tx_rem, 1'b1);
                    OFS_6: st_nxt.rdata = len_byte(st_r.rx_cnt, 1'b0);
                    OFS_7: st_nxt.rdata = len_byte(st_r.rx_cnt, 1'b1);
                    default: st_nxt.rdata = BYTE_ZERO;
                endcase
            end else if (s5) begin
                case (ADDR)
                    OFS_0: st_nxt.rdata = st_r.fdiv[DATA_W-1:0];
                    OFS_1: st_nxt.rdata = st_r.fdiv[DIV_W-1:DATA_W];
                    OFS_2: st_nxt.rdata = st_r.fcmd;
                    OFS_4: st_nxt.rdata = st_r.cfg1;
                    OFS_5: st_nxt.rdata = FS_QUEUE_BOTTOM;
                    OFS_6: st_nxt.rdata = len_byte(RX_LEN_QUEUE, 1'b0);
                    OFS_7: st_nxt.rdata = len_byte(RX_LEN_QUEUE, 1'b1);
                    default: st_nxt.rdata = BYTE_ZERO;
                endcase
            end
        end

        // timer: down-counter with reload
        if (st_r.tmr_en && ms_tick) begin
            if (st_r.tmr_cnt == TMR_ZERO) begin
                st_nxt.tmr_flag = 1'b1;
                st_nxt.tmr_cnt = st_r.tmr_prog;
            end else begin
                st_nxt.tmr_cnt = st_r.tmr_cnt - TMR_ONE;
            end
        end

        // transmit splitting
        if (TX_STREAM_END) begin
            st_nxt.tx_rem = st_r.tx_len;
        end else if (TX_BYTE_SENT && automatic_packet_mode && st_r.tx_len != FLEN_ZERO) begin
            if (st_r.tx_rem <= FLEN_ONE) begin
                st_nxt.tx_rem = st_r.tx_len;
                st_nxt.tx_split = 1'b1;
            end else begin
                st_nxt.tx_rem = st_r.tx_rem - FLEN_ONE;
            end
        end

        // receive length limit
        if (RX_START_FLAG) begin
            st_nxt.rx_cnt = FLEN_ZERO;
            st_nxt.rx_exc = 1'b0;
        end else if (RX_BYTE_IN && !st_r.rx_exc) begin
            if (st_r.rx_cnt >= st_r.rx_lim) begin
                st_nxt.rx_exc = 1'b1;
            end else begin
                st_nxt.rx_cnt = st_r.rx_cnt + FLEN_ONE;
                st_nxt.rx_we = 1'b1;
            end
        end

        // fast to serial change loads the divisor latch
        if (st_r.fast_q && !FAST_MODE && st_r.fcmd[FCMD_ENABLE_BIT]
            && st_r.fcmd[FCMD_BAUD_LOAD_BIT]) begin
            st_nxt.adv_div = st_r.fdiv;
            st_nxt.adv_load = 1'b1;
        end

        // register writes
        if (WR) begin
            if (ADDR == OFS_SEL) begin
                st_nxt.sel = WDATA;
            end else if (s4) begin
                case (ADDR)
                    OFS_0: st_nxt.tmr_prog[DATA_W-1:0] = WDATA;
                    OFS_1: st_nxt.tmr_prog[TMR_W-1:DATA_W] = WDATA[THI_W-1:0];
                    OFS_2: begin
                        st_nxt.mode = WDATA[MSL_MODE_LO +: MODE_W];
                        st_nxt.tmr_test = WDATA[MSL_TEST_BIT];
                        st_nxt.tmr_en = WDATA[MSL_EN_BIT];
                        if (WDATA[MSL_EN_BIT] && !st_r.tmr_en) begin
                            st_nxt.tmr_cnt = st_r.tmr_prog;
                        end
                    end
                    OFS_4: begin
                        st_nxt.tx_len[DATA_W-1:0] = WDATA;
                        st_nxt.tx_rem[DATA_W-1:0] = WDATA;
                    end
                    OFS_5: begin
                        st_nxt.tx_len[FLEN_W-1:DATA_W] = WDATA[HI_W-1:0];
                        st_nxt.tx_rem[FLEN_W-1:DATA_W] = WDATA[HI_W-1:0];
                    end
                    OFS_6: st_nxt.rx_lim[DATA_W-1:0] = WDATA;
                    OFS_7: st_nxt.rx_lim[FLEN_W-1:DATA_W] = WDATA[HI_W-1:0];
                    default: st_nxt.sel = st_r.sel;
                endcase
            end else if (s5) begin
                case (ADDR)
                    OFS_0: st_nxt.fdiv[DATA_W-1:0] = WDATA;
                    OFS_1: st_nxt.fdiv[DIV_W-1:DATA_W] = WDATA;
                    OFS_2: st_nxt.fcmd = WDATA;
                    OFS_4: st_nxt.cfg1 = WDATA;
                    default: st_nxt.sel = st_r.sel;
                endcase
            end
        end

        // owner clear loses against a same-cycle set
        if (TIMER_FLAG_CLR && !(st_r.tmr_en && ms_tick && st_r.tmr_cnt == TMR_ZERO)) begin
            st_nxt.tmr_flag = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            st_r <= '0;
            st_r.sel <= SEL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign RDATA = st_r.rdata;
    assign BANK_SEL = st_r.sel;
    assign TIMER_IRQ_FLAG = st_r.tmr_flag;
    assign IR_MODE = st_r.mode;
    assign AUTO_PACKET = st_r.cfg1[CFG1_AUTO_PACKET_BIT];
    assign TX_FRAME_SPLIT = st_r.tx_split;
    assign RX_FIFO_WE = st_r.rx_we;
    assign MAX_LEN_EXCEEDED = st_r.rx_exc;
    assign ADV_DIV_LOAD = st_r.adv_load;
    assign ADV_DIV = st_r.adv_div;
endmodule

/* include/irsets_pkg.sv */
// constants, offsets and field layout of register sets three to five
package irsets_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int TMR_W = 12;
    localparam int FLEN_W = 13;
    localparam int DIV_W = 16;
    localparam int HI_W = FLEN_W - DATA_W;
    localparam int THI_W = TMR_W - DATA_W;

    // register offsets inside a set
    localparam logic [ADDR_W-1:0] OFS_0 = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_1 = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_2 = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_SEL = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_4 = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_5 = 3'h5;
    localparam logic [ADDR_W-1:0] OFS_6 = 3'h6;
    localparam logic [ADDR_W-1:0] OFS_7 = 3'h7;

    // selector codes, also what the selector reads back in each set
    localparam logic [DATA_W-1:0] SEL_SET3 = 8'he4;
    localparam logic [DATA_W-1:0] SEL_SET4 = 8'he8;
    localparam logic [DATA_W-1:0] SEL_SET5 = 8'hec;
    localparam logic [DATA_W-1:0] SEL_RESET = 8'he4;

    // arbitrary neutral version code
    localparam logic [DATA_W-1:0] VERSION_DEFAULT = 8'h5a;

    // mode-select fields
    localparam int MSL_EN_BIT = 0;
    localparam int MSL_TEST_BIT = 1;
    localparam int MSL_MODE_LO = 2;
    localparam int MODE_W = 2;
    localparam logic [MODE_W-1:0] MODE_LEGACY_IR = 2'h0;
    localparam logic [MODE_W-1:0] MODE_CONSUMER_IR = 2'h1;
    localparam logic [MODE_W-1:0] MODE_LEGACY_ASK = 2'h2;
    localparam logic [MODE_W-1:0] MODE_LEGACY_SIR = 2'h3;

    // set-five fields
    localparam int CFG1_AUTO_PACKET_BIT = 5;
    localparam int FCMD_ENABLE_BIT = 0;
    localparam int FCMD_BAUD_LOAD_BIT = 1;

    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [TMR_W-1:0] TMR_ZERO = 12'h000;
    localparam logic [TMR_W-1:0] TMR_ONE = 12'h001;
    localparam logic [FLEN_W-1:0] FLEN_ZERO = 13'h0000;
    localparam logic [FLEN_W-1:0] FLEN_ONE = 13'h0001;
    localparam logic [DIV_W-1:0] DIV_ZERO = 16'h0000;

    // millisecond tick
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PRE_W = 16;
endpackage

/* hdl/ms_prescaler.sv */
// fixed prescaler giving a one-cycle millisecond tick
`timescale 1ns/1ps
module ms_prescaler #(
    parameter int CYCLES = irsets_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    output logic tick
);
    import irsets_pkg::*;

    typedef struct packed {
        logic [PRE_W-1:0] cnt;
        logic tick;
    } pre_s;

    localparam logic [PRE_W-1:0] LAST = PRE_W'(CYCLES - 1);

    pre_s st_r;
    pre_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (st_r.cnt == LAST) begin
            st_nxt.cnt = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + PRE_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule

/* bench/irsets_sva.sv */
// assertions on the register-set block ports
`timescale 1ns/1ps
module irsets_sva import irsets_pkg::*; #(
    parameter logic [DATA_W-1:0] VERSION_ID = VERSION_DEFAULT
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [DATA_W-1:0] RDATA,
    input wire logic [DATA_W-1:0] MIRROR_CTRL,
    input wire logic [DATA_W-1:0] MIRROR_FIFO_CTRL,
    input wire logic TIMER_FLAG_CLR,
    input wire logic TX_BYTE_SENT,
    input wire logic [DATA_W-1:0] BANK_SEL,
    input wire logic TIMER_IRQ_FLAG,
    input wire logic [MODE_W-1:0] IR_MODE,
    input wire logic AUTO_PACKET,
    input wire logic TX_FRAME_SPLIT,
    input wire logic RX_FIFO_WE,
    input wire logic MAX_LEN_EXCEEDED,
    input wire logic ADV_DIV_LOAD
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    wire s3 = BANK_SEL == SEL_SET3;
    wire s4 = BANK_SEL == SEL_SET4;
    a_version_read: assert property (RD && ADDR == OFS_0 && s3 |=> RDATA == VERSION_ID)
        else $error("version read wrong");
    a_mirror_ctrl: assert property (RD && ADDR == OFS_1 && s3 |=> RDATA == $past(MIRROR_CTRL))
        else $error("control mirror wrong");
    a_mirror_fifo: assert property (RD && ADDR == OFS_2 && s3 |=> RDATA == $past(MIRROR_FIFO_CTRL))
        else $error("fifo control mirror wrong");
    a_sel_write: assert property (WR && ADDR == OFS_SEL |=> BANK_SEL == $past(WDATA))
        else $error("selector not written");
    a_sel_read3: assert property (RD && ADDR == OFS_SEL && s3 |=> RDATA == SEL_SET3)
        else $error("set three selector read wrong");
    a_sel_read4: assert property (RD && ADDR == OFS_SEL && s4 |=> RDATA == SEL_SET4)
        else $error("set four selector read wrong");
    a_mode_bits: assert property (WR && ADDR == OFS_2 && s4 |=> IR_MODE == $past(WDATA[3:2]))
        else $error("mode bits not taken");
    a_flag_hold: assert property (TIMER_IRQ_FLAG && !TIMER_FLAG_CLR |=> TIMER_IRQ_FLAG)
        else $error("timer flag dropped");
    a_drop_excess: assert property (MAX_LEN_EXCEEDED |-> !RX_FIFO_WE)
        else $error("byte written after overlength");
    a_split_cause: assert property (TX_FRAME_SPLIT |-> AUTO_PACKET && $past(TX_BYTE_SENT))
        else $error("split without sent byte");
    a_load_pulse: assert property (ADV_DIV_LOAD |=> !ADV_DIV_LOAD)
        else $error("divisor load longer than a cycle");
endmodule
bind ir_uart_sets_timer_framelen irsets_sva #(.VERSION_ID(VERSION_ID)) chk (
    .CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .MIRROR_CTRL(MIRROR_CTRL), .MIRROR_FIFO_CTRL(MIRROR_FIFO_CTRL),
    .TIMER_FLAG_CLR(TIMER_FLAG_CLR), .TX_BYTE_SENT(TX_BYTE_SENT), .BANK_SEL(BANK_SEL),
    .TIMER_IRQ_FLAG(TIMER_IRQ_FLAG), .IR_MODE(IR_MODE), .AUTO_PACKET(AUTO_PACKET),
    .TX_FRAME_SPLIT(TX_FRAME_SPLIT), .RX_FIFO_WE(RX_FIFO_WE),
    .MAX_LEN_EXCEEDED(MAX_LEN_EXCEEDED), .ADV_DIV_LOAD(ADV_DIV_LOAD));

/* bench/irsets_far_side.sv */
// far side: set-zero values, status queues, transceiver events, speed mode
`timescale 1ns/1ps
module irsets_far_side (
    input wire logic clk,
    output logic [7:0] ctrl,
    output logic [7:0] fifo_ctrl,
    output logic [7:0] fs_bottom,
    output logic [12:0] len_queue,
    output logic [4:0] ev,
    output logic fast
);
    initial begin
        ctrl = 8'ha5;
        fifo_ctrl = 8'h5c;
        fs_bottom = 8'h90;
        len_queue = 13'h1abc;
        ev = 5'h00;
        fast = 1'b0;
    end
    // one-cycle event: 0 clear, 1 sent, 2 end, 3 start, 4 byte in
    task automatic pulse(input int i);
        @(posedge clk) ev[i] <= 1'b1;
        @(posedge clk) ev[i] <= 1'b0;
    endtask
    // medium/fast mode, then back to serial
    task automatic drop();
        @(posedge clk) fast <= 1'b1;
        repeat (2) @(posedge clk);
        fast <= 1'b0;
    endtask
    // new set-zero values and queue contents, applied at one edge
    task automatic load(input logic [7:0] c, input logic [7:0] f, input logic [7:0] s,
                        input logic [12:0] q);
        @(posedge clk) {ctrl, fifo_ctrl, fs_bottom, len_queue} <= {c, f, s, q};
    endtask
endmodule

/* bench/ir_uart_sets_timer_framelen_bench.sv */
// self-checking bench for the register-set block
`timescale 1ns/1ps
module ir_uart_sets_timer_framelen_bench;
    import irsets_pkg::*;
    localparam logic [DATA_W-1:0] VID = 8'h3c; // arbitrary
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [ADDR_W-1:0] addr = 3'h0;
    logic [DATA_W-1:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [7:0] rdata, bank_sel, ctrl, fctrl, fsb;
    logic [12:0] lq;
    logic [4:0] ev;
    logic [1:0] mode;
    logic [15:0] adv_div;
    logic fast, irq, auto_pkt, split, fifo_we, mx, div_load;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    int n_split = 0;
    int n_we = 0;
    int n_load = 0;
    int n, t1;
    always #12.5 clk = ~clk;
    irsets_far_side far (.clk(clk), .ctrl(ctrl), .fifo_ctrl(fctrl), .fs_bottom(fsb),
        .len_queue(lq), .ev(ev), .fast(fast));
    ir_uart_sets_timer_framelen #(.TICK_CYCLES(4), .VERSION_ID(VID)) uut (
        .CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
        .RDATA(rdata), .MIRROR_CTRL(ctrl), .MIRROR_FIFO_CTRL(fctrl), .FS_QUEUE_BOTTOM(fsb),
        .RX_LEN_QUEUE(lq), .TIMER_FLAG_CLR(ev[0]), .TX_BYTE_SENT(ev[1]),
        .TX_STREAM_END(ev[2]), .RX_START_FLAG(ev[3]), .RX_BYTE_IN(ev[4]), .FAST_MODE(fast),
        .BANK_SEL(bank_sel), .TIMER_IRQ_FLAG(irq), .IR_MODE(mode), .AUTO_PACKET(auto_pkt),
        .TX_FRAME_SPLIT(split), .RX_FIFO_WE(fifo_we), .MAX_LEN_EXCEEDED(mx),
        .ADV_DIV_LOAD(div_load), .ADV_DIV(adv_div));
    task automatic conclude();
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk) {wr_s, addr, wdata} <= {1'b1, a, d};
        @(posedge clk) wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
        @(posedge clk) {rd_s, addr} <= {1'b1, a};
        @(posedge clk) rd_s <= 1'b0;
        #1 chk(nm, 16'(e), 16'(rdata));
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        n_split <= n_split + 32'(split);
        n_we <= n_we + 32'(fifo_we);
        n_load <= n_load + 32'(div_load);
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        #1 chk("bank_sel", 16'(SEL_RESET), 16'(bank_sel));
        rd(OFS_0, VID, "version");
        rd(OFS_1, 8'ha5, "mirror_ctrl");
        rd(OFS_2, 8'h5c, "mirror_fifo");
        wr(OFS_0, 8'hff);
        rd(OFS_0, VID, "version_ro");
        for (int a = 3; a < 8; a++) rd(a[2:0], a == 3 ? SEL_SET3 : 8'h00, "set3_read");
        wr(OFS_SEL, SEL_SET4);
        rd(OFS_SEL, SEL_SET4, "sel4");
        wr(OFS_0, 8'hff);
        wr(OFS_1, 8'hff);
        wr(OFS_2, 8'h02);
        rd(OFS_1, 8'h0f, "tmr_hi_prog");
        wr(OFS_2, 8'h00);
        rd(OFS_1, 8'h00, "tmr_hi_live");
        repeat (20) @(posedge clk);
        #1 chk("irq_stopped", 16'h0, 16'(irq));
        wr(OFS_0, 8'h03);
        wr(OFS_1, 8'h00);
        wr(OFS_2, 8'h01);
        for (n = 0; n < 40 && irq !== 1'b1; n++) @(posedge clk) #1;
        chk("irq_delay", 16'h1, 16'(n >= 13 && n <= 16));
        t1 = cyc;
        repeat (3) @(posedge clk);
        #1 chk("irq_held", 16'h1, 16'(irq));
        far.pulse(0);
        #1 chk("irq_clear", 16'h0, 16'(irq));
        for (n = 0; n < 40 && irq !== 1'b1; n++) @(posedge clk) #1;
        chk("irq_period", 16'd16, 16'(cyc - t1));
        for (int m = 0; m < 4; m++) begin
            wr(OFS_2, 8'(m << 2));
            #1 chk("ir_mode", 16'(m), 16'(mode));
        end
        wr(OFS_SEL, SEL_SET5);
        wr(OFS_4, 8'h20);
        #1 chk("auto_packet", 16'h1, 16'(auto_pkt));
        rd(OFS_5, 8'h90, "fs_queue");
        rd(OFS_7, 8'h1a, "len_queue_hi");
        wr(OFS_0, 8'h34);
        wr(OFS_1, 8'h12);
        for (int k = 0; k < 2; k++) begin
            wr(OFS_2, k == 1 ? 8'h03 : 8'h01);
            far.drop();
            repeat (8) @(posedge clk);
            chk("div_loads", 16'(k), 16'(n_load));
        end
        chk("adv_div", 16'h1234, adv_div);
        wr(OFS_SEL, SEL_SET4);
        wr(OFS_4, 8'h03);
        wr(OFS_5, 8'he0);
        rd(OFS_5, 8'h00, "tx_len_hi");
        rd(OFS_4, 8'h03, "tx_remain");
        far.pulse(1);
        rd(OFS_4, 8'h02, "tx_remain");
        repeat (2) far.pulse(1);
        repeat (3) @(posedge clk);
        chk("tx_split", 16'h1, 16'(n_split));
        rd(OFS_4, 8'h03, "tx_reload");
        wr(OFS_6, 8'h02);
        wr(OFS_7, 8'h00);
        far.pulse(3);
        repeat (2) far.pulse(4);
        rd(OFS_6, 8'h02, "rx_count");
        repeat (2) far.pulse(4);
        @(posedge clk) #1;
        chk("max_len", 16'h1, 16'(mx));
        chk("rx_writes", 16'h2, 16'(n_we));
        far.pulse(3);
        @(posedge clk) #1;
        chk("max_len_clr", 16'h0, 16'(mx));
        far.pulse(4);
        rd(OFS_6, 8'h01, "rx_restart");
        far.pulse(1);
        far.pulse(2);
        rd(OFS_4, 8'h03, "tx_stream_end");
        rd(OFS_2, 8'h0c, "mode_reg");
        far.load(8'h3c, 8'hc3, 8'h10, 13'h0a5f);
        wr(OFS_SEL, SEL_SET3);
        rd(OFS_1, 8'h3c, "mirror_ctrl_new");
        rd(OFS_2, 8'hc3, "mirror_fifo_new");
        wr(OFS_SEL, SEL_SET5);
        rd(OFS_SEL, SEL_SET5, "sel5");
        rd(OFS_5, 8'h10, "fs_queue_new");
        rd(OFS_6, 8'h5f, "len_queue_lo");
        rd(OFS_7, 8'h0a, "len_queue_hi_new");
        rd(OFS_0, 8'h34, "flow_div_lo");
        rd(OFS_4, 8'h20, "cfg1_read");
        @(posedge clk) srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        #1 chk("bank_sel_rst", 16'(SEL_RESET), 16'(bank_sel));
        chk("mode_rst", 16'h0, 16'(mode));
        conclude();
    end
endmodule
